// [hw/sdr_pkg.sv]
// sdr_pkg: register map, field positions, reset values and timing counts
// of the step/direction and reference switch unit.
// assumes a 25 MHz system clock and a byte-addressed 32-bit register port.
package sdr_pkg;

    // ==========================================================
    // clock and timing
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned STEP_BASE_CYCLES = 16;
    localparam int unsigned STEP_MAX_DIV = 32;
    localparam int unsigned PULSE_CNT_W = 9;

    // ==========================================================
    // widths
    localparam int unsigned ADDR_W = 6;
    localparam int unsigned POS_W = 24;
    localparam int unsigned VEL_W = 12;
    localparam int unsigned PHASE_W = 16;

    // ==========================================================
    // register byte offsets
    localparam logic [5:0] OFF_IF_CONFIG = 6'h00;
    localparam logic [5:0] OFF_GLOBAL = 6'h04;
    localparam logic [5:0] OFF_TARGET_POS = 6'h08;
    localparam logic [5:0] OFF_CUR_POS = 6'h0c;
    localparam logic [5:0] OFF_CUR_VEL = 6'h10;
    localparam logic [5:0] OFF_TARGET_VEL = 6'h14;
    localparam logic [5:0] OFF_VEL_MAX = 6'h18;
    localparam logic [5:0] OFF_TOLERANCE = 6'h1c;
    localparam logic [5:0] OFF_LATCHED_POS = 6'h20;
    localparam logic [5:0] OFF_STATUS = 6'h24;

    // ==========================================================
    // interface configuration fields
    localparam int unsigned CFG_INV_REF_BIT = 0;
    localparam int unsigned CFG_PORT_EN_BIT = 1;
    localparam int unsigned CFG_STOP_EN_BIT = 2;
    localparam int unsigned CFG_VEL_MODE_BIT = 3;
    localparam int unsigned CFG_W = 4;
    localparam logic [3:0] CFG_RESET = 4'h0;

    // global parameter fields
    localparam int unsigned GLB_DIV_LSB = 0;
    localparam int unsigned GLB_DIV_W = 4;
    localparam int unsigned GLB_DUAL_BIT = 21;
    localparam logic [3:0] DIV_RESET = 4'h0;
    localparam logic DUAL_RESET = 1'b0;

    // status fields
    localparam int unsigned ST_LEFT_BIT = 0;
    localparam int unsigned ST_RIGHT_BIT = 1;
    localparam int unsigned ST_ARMED_BIT = 2;
    localparam int unsigned ST_MISMATCH_BIT = 3;
    localparam int unsigned ST_MOVING_BIT = 4;
    localparam int unsigned ST_REFVALID_BIT = 5;

    localparam logic [11:0] VEL_MAX_RESET = 12'h100;

endpackage : sdr_pkg

// [hw/sdr_step_gen.sv]
// sdr_step_gen: step pulse former with pulse length, low time and
// direction setup delay, all of one programmed pulse length.
// assumes req is held until taken is seen; everything on CLK.
`timescale 1ns/1ns
`default_nettype none
module sdr_step_gen
    import sdr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic [sdr_pkg::GLB_DIV_W-1:0] divider,
    input wire logic req,
    input wire logic dir_in,
    output logic taken,
    output logic step_o,
    output logic dir_o
);
    typedef enum logic [1:0] {SG_IDLE, SG_HIGH, SG_LOW, SG_SETUP} sdr_sg_state_t;

    sdr_sg_state_t state_q;
    logic [PULSE_CNT_W-1:0] cnt_q;
    logic step_q;
    logic dir_q;
    wire [PULSE_CNT_W-1:0] len_m1;
    wire cnt_done;
    wire want;

    // 16 * (1 + divider) cycles; held high and low each for one length
    assign len_m1 = PULSE_CNT_W'(STEP_BASE_CYCLES * ({1'b0, divider} + 5'd1) - 1);
    assign cnt_done = (cnt_q == '0);
    assign want = enable && (state_q == SG_IDLE) && req;
    assign taken = want && (dir_in == dir_q);
    assign step_o = step_q;
    assign dir_o = dir_q;

    // ==========================================================
    // pulse sequencer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= SG_IDLE;
            cnt_q <= '0;
            step_q <= 1'b1;
            dir_q <= 1'b1;
        end else if (!enable) begin
            // pins idle high until the port is switched on
            state_q <= SG_IDLE;
            step_q <= 1'b1;
            dir_q <= 1'b1;
            cnt_q <= '0;
        end else begin
            case (state_q)
                SG_IDLE: begin
                    step_q <= 1'b0;
                    if (want && !taken) begin
                        dir_q <= dir_in;
                        cnt_q <= len_m1;
                        state_q <= SG_SETUP;
                    end else if (taken) begin
                        step_q <= 1'b1;
                        cnt_q <= len_m1;
                        state_q <= SG_HIGH;
                    end
                end
                SG_HIGH: begin
                    cnt_q <= cnt_q - 1'b1;
                    if (cnt_done) begin
                        step_q <= 1'b0;
                        cnt_q <= len_m1;
                        state_q <= SG_LOW;
                    end
                end
                SG_LOW, SG_SETUP: begin
                    // at least 2 x 16 + 1 cycles per step caps rate at clk / 33
                    cnt_q <= cnt_q - 1'b1;
                    if (cnt_done) begin
                        state_q <= SG_IDLE;
                    end
                end
                default: begin
                    state_q <= SG_IDLE;
                end
            endcase
        end
    end

endmodule // sdr_step_gen
`default_nettype wire

// [hw/sdr_unit.sv]
// sdr_unit: step/direction generator and reference switch handling with
// position latch, tolerance window and stop switches.
// assumes a register master on CLK and switch pins from outside the domain.
`timescale 1ns/1ns
`default_nettype none
module sdr_unit
    import sdr_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [sdr_pkg::ADDR_W-1:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire logic REF_L,
    input wire logic REF_R,
    output logic STEP_OUT,
    output logic DIR_OUT
);
    import sdr_pkg::*;

    // ==========================================================
    // helpers
    function automatic logic [VEL_W-1:0] vel_mag(input logic [VEL_W-1:0] v);
        vel_mag = v[VEL_W-1] ? VEL_W'(-v) : v;
    endfunction

    function automatic logic [POS_W-1:0] pos_dist(input logic [POS_W-1:0] a,
                                                  input logic [POS_W-1:0] b);
        logic [POS_W-1:0] d;
        d = a - b;
        pos_dist = d[POS_W-1] ? POS_W'(-d) : d;
    endfunction

    // ==========================================================
    // state
    logic [CFG_W-1:0] cfg_q;
    logic [GLB_DIV_W-1:0] div_q;
    logic dual_q;
    logic [POS_W-1:0] target_q;
    logic [POS_W-1:0] pos_q;
    logic [POS_W-1:0] pos_d;
    logic [VEL_W-1:0] vel_q;
    logic [VEL_W-1:0] vel_d;
    logic [VEL_W-1:0] vtgt_q;
    logic [VEL_W-1:0] vmax_q;
    logic [POS_W-1:0] tol_q;
    logic [POS_W-1:0] latch_q;
    logic latch_dir_q;
    logic armed_q;
    logic ref_valid_q;
    logic mismatch_q;
    logic [PHASE_W-1:0] phase_q;
    logic pend_q;
    logic [31:0] rdata_q;
    logic [1:0] l_sync_q;
    logic [1:0] r_sync_q;
    logic l_prev_q;

    // ==========================================================
    // register decode
    wire wr_cfg = WR && (ADDR == OFF_IF_CONFIG);
    wire wr_glb = WR && (ADDR == OFF_GLOBAL);
    wire wr_tgt = WR && (ADDR == OFF_TARGET_POS);
    wire wr_pos = WR && (ADDR == OFF_CUR_POS);
    wire wr_vel = WR && (ADDR == OFF_CUR_VEL);
    wire wr_vtgt = WR && (ADDR == OFF_TARGET_VEL);
    wire wr_vmax = WR && (ADDR == OFF_VEL_MAX);
    wire wr_tol = WR && (ADDR == OFF_TOLERANCE);
    wire wr_latch = WR && (ADDR == OFF_LATCHED_POS);

    wire inv_ref = cfg_q[CFG_INV_REF_BIT];
    wire port_en = cfg_q[CFG_PORT_EN_BIT];
    wire stop_en = cfg_q[CFG_STOP_EN_BIT];
    wire vel_mode = cfg_q[CFG_VEL_MODE_BIT];

    // ==========================================================
    // switch inputs
    wire l_act = l_sync_q[1] ^ inv_ref;
    wire r_act = (r_sync_q[1] ^ inv_ref) && dual_q;
    wire l_edge = l_act && !l_prev_q;

    wire moving = (vel_q != '0);
    wire vel_neg = vel_q[VEL_W-1];
    // reference window keeps the series reference contact from stopping us
    wire in_window = (tol_q != '0) && ref_valid_q
                     && (pos_dist(pos_q, latch_q) <= tol_q);
    wire halt_l = stop_en && l_act && moving && vel_neg && !in_window;
    wire halt_r = stop_en && r_act && moving && !vel_neg;
    wire halt = halt_l || halt_r;
    wire arrived = !vel_mode && moving && (pos_q == target_q) && !wr_tgt && !wr_vel;

    // ==========================================================
    // step rate and generator
    wire [PHASE_W:0] phase_sum = {1'b0, phase_q} + {{(PHASE_W - VEL_W + 1){1'b0}}, vel_mag(vel_q)};
    wire step_taken;
    wire dir_pin;
    wire gen_req = pend_q && port_en && !halt;

    sdr_step_gen u_gen (
        .clk(CLK),
        .rst_n(RST_N),
        .enable(port_en),
        .divider(div_q),
        .req(gen_req),
        .dir_in(!vel_neg),
        .taken(step_taken),
        .step_o(STEP_OUT),
        .dir_o(dir_pin)
    );
    assign DIR_OUT = dir_pin;

    // ==========================================================
    // next position and velocity
    always_comb begin
        pos_d = pos_q;
        if (step_taken) begin
            pos_d = dir_pin ? pos_q + 1'b1 : pos_q - 1'b1;
        end
        if (wr_pos) begin
            pos_d = WDATA[POS_W-1:0];
        end
    end

    always_comb begin
        vel_d = vel_q;
        if (wr_tgt && !vel_mode && (WDATA[POS_W-1:0] != pos_q)) begin
            // start toward the new target at the top speed
            vel_d = ($signed(WDATA[POS_W-1:0] - pos_q) < 0) ? VEL_W'(-vmax_q) : vmax_q;
        end
        if (wr_vtgt && vel_mode) begin
            vel_d = WDATA[VEL_W-1:0];
        end
        if (wr_vel) begin
            vel_d = WDATA[VEL_W-1:0];
        end
        if (halt || arrived) begin
            vel_d = '0;
        end
    end

    // ==========================================================
    // configuration registers
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cfg_q <= CFG_RESET;
            div_q <= DIV_RESET;
            dual_q <= DUAL_RESET;
            vmax_q <= VEL_MAX_RESET;
            tol_q <= '0;
            target_q <= '0;
            vtgt_q <= '0;
        end else begin
            if (wr_cfg) cfg_q <= WDATA[CFG_W-1:0];
            if (wr_glb) begin
                div_q <= WDATA[GLB_DIV_LSB +: GLB_DIV_W];
                dual_q <= WDATA[GLB_DUAL_BIT];
            end
            if (wr_vmax) vmax_q <= WDATA[VEL_W-1:0];
            if (wr_tol) tol_q <= WDATA[POS_W-1:0];
            if (wr_tgt) target_q <= WDATA[POS_W-1:0];
            if (wr_vtgt) vtgt_q <= WDATA[VEL_W-1:0];
        end
    end

    // ==========================================================
    // motion
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pos_q <= '0;
            vel_q <= '0;
            phase_q <= '0;
            pend_q <= 1'b0;
        end else begin
            pos_q <= pos_d;
            vel_q <= vel_d;
            phase_q <= (moving && port_en) ? phase_sum[PHASE_W-1:0] : '0;
            // a carry raised while a step is taken is kept for the next step
            if (halt || arrived || !moving) begin
                pend_q <= 1'b0;
            end else if (moving && port_en && phase_sum[PHASE_W]) begin
                pend_q <= 1'b1;
            end else if (step_taken) begin
                pend_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // switch sync, position latch and reference check
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            l_sync_q <= 2'b00;
            r_sync_q <= 2'b00;
            l_prev_q <= 1'b0;
            latch_q <= '0;
            latch_dir_q <= 1'b0;
            armed_q <= 1'b0;
            ref_valid_q <= 1'b0;
            mismatch_q <= 1'b0;
        end else begin
            l_sync_q <= {l_sync_q[0], REF_L};
            r_sync_q <= {r_sync_q[0], REF_R};
            l_prev_q <= l_act;
            if (wr_latch) begin
                armed_q <= 1'b1;
                mismatch_q <= 1'b0;
            end else if (armed_q && l_edge) begin
                latch_q <= pos_q;
                latch_dir_q <= vel_neg;
                armed_q <= 1'b0;
                ref_valid_q <= 1'b1;
            end
            // only a pass in the capture direction sees the same edge;
            // a mismatch seen in the clearing cycle still sets the flag
            if (!armed_q && ref_valid_q && l_edge
                && (vel_neg == latch_dir_q) && (pos_q != latch_q)) begin
                mismatch_q <= 1'b1;
            end
        end
    end

    // ==========================================================
    // read back
    // bits placed by index: a shifted 1-bit flag would lose its value
    logic [31:0] status_w;
    logic [31:0] glb_w;
    always_comb begin
        status_w = 32'h00000000;
        status_w[ST_LEFT_BIT] = l_act;
        status_w[ST_RIGHT_BIT] = r_act;
        status_w[ST_ARMED_BIT] = armed_q;
        status_w[ST_MISMATCH_BIT] = mismatch_q;
        status_w[ST_MOVING_BIT] = moving;
        status_w[ST_REFVALID_BIT] = ref_valid_q;
        glb_w = 32'h00000000;
        glb_w[GLB_DUAL_BIT] = dual_q;
        glb_w[GLB_DIV_LSB +: GLB_DIV_W] = div_q;
    end
    wire [31:0] rd_mux =
        (ADDR == OFF_IF_CONFIG) ? {{(32 - CFG_W){1'b0}}, cfg_q} :
        (ADDR == OFF_GLOBAL) ? glb_w :
        (ADDR == OFF_TARGET_POS) ? {8'h00, target_q} :
        (ADDR == OFF_CUR_POS) ? {8'h00, pos_q} :
        (ADDR == OFF_CUR_VEL) ? {20'h00000, vel_q} :
        (ADDR == OFF_TARGET_VEL) ? {20'h00000, vtgt_q} :
        (ADDR == OFF_VEL_MAX) ? {20'h00000, vmax_q} :
        (ADDR == OFF_TOLERANCE) ? {8'h00, tol_q} :
        (ADDR == OFF_LATCHED_POS) ? {8'h00, latch_q} :
        (ADDR == OFF_STATUS) ? status_w : 32'h00000000;

    // data valid only in the cycle after the read strobe
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rdata_q <= 32'h00000000;
        end else begin
            rdata_q <= RD ? rd_mux : 32'h00000000;
        end
    end
    assign RDATA = rdata_q;

endmodule // sdr_unit
`default_nettype wire

// [verification/sdr_unit_chk.sv]
// sdr_unit_chk: port-level checks of the step/direction unit.
// assumes it is bound onto sdr_unit; config is mirrored from bus writes.
`timescale 1ns/1ns
`default_nettype none
module sdr_unit_chk
    import sdr_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [sdr_pkg::ADDR_W-1:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [31:0] RDATA,
    input wire logic REF_L,
    input wire logic REF_R,
    input wire logic STEP_OUT,
    input wire logic DIR_OUT
);
    // ==========
    // mirrors and pulse timers
    logic [3:0] cfg_q, div_q;
    logic [5:0] ra_q;
    logic [9:0] hi_q, lo_q, dc_q;
    logic dual_q, rd_q, enp_q, st_q, dir_q, pv_q, lv_q;
    wire en = cfg_q[1] && enp_q;
    wire [9:0] len = {1'b0, {1'b0, div_q} + 5'h01, 4'h0};
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            {cfg_q, div_q, dual_q, rd_q, ra_q} <= '0;
        end else begin
            rd_q <= RD;
            ra_q <= ADDR;
            if (WR && ADDR == OFF_IF_CONFIG) cfg_q <= WDATA[3:0];
            if (WR && ADDR == OFF_GLOBAL) div_q <= WDATA[3:0];
            if (WR && ADDR == OFF_GLOBAL) dual_q <= WDATA[GLB_DUAL_BIT];
        end
    end
    // only pulses begun while enabled are timed: enabling drops the idle high
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            {enp_q, st_q, dir_q, pv_q, lv_q} <= 5'b01100;
            {hi_q, lo_q, dc_q} <= {20'h0, 10'h3ff};
        end else begin
            enp_q <= cfg_q[1];
            st_q <= STEP_OUT;
            dir_q <= DIR_OUT;
            pv_q <= en && STEP_OUT && (!st_q || pv_q);
            lv_q <= en && !STEP_OUT && ((st_q && pv_q) || lv_q);
            hi_q <= STEP_OUT ? hi_q + 10'h001 : 10'h000;
            lo_q <= STEP_OUT ? 10'h000 : lo_q + {9'h0, lo_q != 10'h3ff};
            dc_q <= (en && DIR_OUT != dir_q) ? 10'h000 : dc_q + {9'h0, dc_q != 10'h3ff};
        end
    end
    // ==========
    // properties
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    sequence s_arm; WR && ADDR == OFF_LATCHED_POS ##1 RD && ADDR == OFF_STATUS; endsequence
    sequence s_right_hit;
        (en && cfg_q[2] && dual_q && (REF_R ^ cfg_q[0]) && DIR_OUT) [*8];
    endsequence
    property p_idle_high; !cfg_q[1] && !enp_q |-> STEP_OUT && DIR_OUT; endproperty
    a_idle_high: assert property (p_idle_high)
        else $error("step pins low while port disabled");
    property p_step_len; $fell(STEP_OUT) && pv_q |-> hi_q == len; endproperty
    a_step_len: assert property (p_step_len)
        else $error("step pulse length wrong");
    property p_low_len; $rose(STEP_OUT) && lv_q |-> lo_q >= len; endproperty
    a_low_len: assert property (p_low_len)
        else $error("step low time too short");
    property p_dir_setup; $rose(STEP_OUT) && en |-> dc_q >= len - 10'h001; endproperty
    a_dir_setup: assert property (p_dir_setup)
        else $error("step too soon after direction change");
    property p_dir_hold; STEP_OUT && pv_q |-> $stable(DIR_OUT); endproperty
    a_dir_hold: assert property (p_dir_hold)
        else $error("direction moved during step pulse");
    property p_rd_idle; !rd_q |-> RDATA == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside read cycle");
    property p_rd_unmapped; rd_q && ra_q > OFF_STATUS |-> RDATA == 32'h0; endproperty
    a_rd_unmapped: assert property (p_rd_unmapped)
        else $error("unmapped read not zero");
    property p_arm; s_arm |=> RDATA[ST_ARMED_BIT]; endproperty
    a_arm: assert property (p_arm)
        else $error("latch not armed by write");
    property p_dual; rd_q && ra_q == OFF_STATUS && !dual_q |-> !RDATA[ST_RIGHT_BIT]; endproperty
    a_dual: assert property (p_dual)
        else $error("right switch seen in single mode");
    property p_stop_right; s_right_hit |-> !$rose(STEP_OUT); endproperty
    a_stop_right: assert property (p_stop_right)
        else $error("step issued against active stop");
endmodule // sdr_unit_chk
`default_nettype wire

// [verification/sdr_drv_model.sv]
// sdr_drv_model: stepper driver on the step/direction pins.
// assumes pins idle high out of reset; counts rising step edges.
`timescale 1ns/1ns
`default_nettype none
module sdr_drv_model #(
    parameter int unsigned MIN_HIGH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic step_in,
    input wire logic dir_in,
    output logic [23:0] pos_o,
    output logic fault_o
);
    // ==========
    // step counter
    logic step_q;
    logic [9:0] hi_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {step_q, hi_q, pos_o, fault_o} <= {1'b1, 35'h0};
        end else begin
            step_q <= step_in;
            hi_q <= step_in ? hi_q + 10'h001 : 10'h000;
            if (step_in && !step_q) pos_o <= dir_in ? pos_o + 24'h1 : pos_o - 24'h1;
            // a pulse narrower than the driver accepts is a lost step
            if (!step_in && step_q && hi_q < 10'(MIN_HIGH)) fault_o <= 1'b1;
        end
    end
endmodule // sdr_drv_model
`default_nettype wire

// [verification/testbench.sv]
// testbench: register-port stimulus, switch pins and step count checks.
// assumes sdr_drv_model on the step pins and sdr_unit_chk bound below.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import sdr_pkg::*;
    logic CLK, RST_N, WR, RD, REF_L, REF_R;
    logic [5:0] ADDR;
    logic [31:0] WDATA, q, r, tgt;
    logic [31:0] seed = 32'd12557;
    logic [23:0] p = 24'h0;
    logic [11:0] v;
    wire [31:0] RDATA;
    wire STEP_OUT, DIR_OUT, fault;
    wire [23:0] mpos;
    int bad_count = 0;
    int n_checks = 0;
    int cyc = 0;
    sdr_unit uut (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .REF_L(REF_L), .REF_R(REF_R), .STEP_OUT(STEP_OUT), .DIR_OUT(DIR_OUT));
    sdr_drv_model drv (.clk(CLK), .rst_n(RST_N), .step_in(STEP_OUT), .dir_in(DIR_OUT),
        .pos_o(mpos), .fault_o(fault));
    // ==========
    // helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [1:0] sw_exp(input logic [3:0] c);
        return {(c[2] ^ c[0]) & c[3], c[1] ^ c[0]};
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge CLK);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge CLK);
        WR <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a);
        @(posedge CLK);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge CLK);
        RD <= 1'b0;
        @(negedge CLK);
        q = RDATA;
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        CLK = 1'b0;
        forever #20 CLK = ~CLK;
    end
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            complete_run();
        end
    end
    // ==========
    // scenarios
    initial begin
        {RST_N, WR, RD, REF_L, REF_R, ADDR, WDATA} = '0;
        repeat (2) @(posedge CLK);
        RST_N <= 1'b1;
        rd(OFF_IF_CONFIG);
        chk("pins", 32'h3, {30'h0, STEP_OUT, DIR_OUT});
        chk("cfg", 32'h0, q);
        rd(OFF_GLOBAL);
        chk("global", 32'h0, q);
        rd(OFF_VEL_MAX);
        chk("vmax", {20'h0, VEL_MAX_RESET}, q);
        wr(6'h28, 32'hffffffff);
        rd(6'h28);
        chk("unmapped", 32'h0, q);
        for (int i = 0; i < 16; i++) begin
            wr(OFF_IF_CONFIG, {31'h0, i[0]});
            wr(OFF_GLOBAL, {10'h0, i[3], 21'h0});
            REF_L <= i[1];
            REF_R <= i[2];
            repeat (4) @(posedge CLK);
            rd(OFF_STATUS);
            chk("switches", {30'h0, sw_exp(i[3:0])}, {30'h0, q[1:0]});
        end
        @(posedge CLK);
        {REF_L, REF_R} <= 2'b00;
        wr(OFF_IF_CONFIG, 32'ha);
        // direction alternates so every run after the first starts with a direction change
        for (int k = 0; k < 3; k++) begin
            r = rnd();
            wr(OFF_GLOBAL, (k == 0) ? 32'hf : {30'h0, r[1:0]});
            r = rnd();
            v = {2'b01, r[9:0]};
            wr(OFF_TARGET_VEL, {20'h0, k[0] ? 12'h0 - v : v});
            repeat (1500) @(posedge CLK);
            wr(OFF_TARGET_VEL, 32'h0);
            repeat (600) @(posedge CLK);
            rd(OFF_CUR_POS);
            chk("position", {8'h0, mpos}, q);
            chk("moved", 32'h1, {31'h0, q[23:0] != p});
            p = q[23:0];
        end
        wr(OFF_GLOBAL, 32'h0);
        wr(OFF_IF_CONFIG, 32'h2);
        tgt = {8'h0, p + 24'd7};
        wr(OFF_TARGET_POS, tgt);
        repeat (2500) @(posedge CLK);
        rd(OFF_CUR_POS);
        chk("target", tgt, q);
        chk("drv count", tgt, {8'h0, mpos});
        r = rnd();
        @(posedge CLK);
        WR <= 1'b1;
        ADDR <= OFF_LATCHED_POS;
        WDATA <= r;
        @(posedge CLK);
        WR <= 1'b0;
        RD <= 1'b1;
        ADDR <= OFF_STATUS;
        @(posedge CLK);
        RD <= 1'b0;
        REF_L <= 1'b1;
        @(negedge CLK);
        chk("armed", 32'h1, {31'h0, RDATA[ST_ARMED_BIT]});
        repeat (8) @(posedge CLK);
        rd(OFF_LATCHED_POS);
        chk("latched", tgt, q);
        rd(OFF_STATUS);
        chk("disarmed", 32'h2, {30'h0, q[ST_REFVALID_BIT], q[ST_ARMED_BIT]});
        @(posedge CLK);
        REF_L <= 1'b0;
        wr(OFF_IF_CONFIG, 32'he);
        wr(OFF_GLOBAL, 32'h00200000);
        wr(OFF_TARGET_VEL, 32'h200);
        repeat (300) @(posedge CLK);
        REF_R <= 1'b1;
        repeat (40) @(posedge CLK);
        rd(OFF_STATUS);
        chk("right stop", 32'h0, {31'h0, q[ST_MOVING_BIT]});
        @(posedge CLK);
        REF_R <= 1'b0;
        wr(OFF_TOLERANCE, 32'h100);
        wr(OFF_TARGET_VEL, 32'he00);
        REF_L <= 1'b1;
        repeat (40) @(posedge CLK);
        rd(OFF_STATUS);
        chk("window", 32'h1, {31'h0, q[ST_MOVING_BIT]});
        wr(OFF_TOLERANCE, 32'h0);
        repeat (40) @(posedge CLK);
        rd(OFF_STATUS);
        chk("left stop", 32'h0, {31'h0, q[ST_MOVING_BIT]});
        rd(OFF_CUR_POS);
        chk("final pos", {8'h0, mpos}, q);
        chk("width", 32'h0, {31'h0, fault});
        complete_run();
    end
endmodule // testbench
bind sdr_unit sdr_unit_chk u_chk (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .REF_L(REF_L), .REF_R(REF_R), .STEP_OUT(STEP_OUT),
    .DIR_OUT(DIR_OUT));
`default_nettype wire
